/* File: clkgen_i2c_map.svh */
// constants for the clock generator two-wire register slave and its master
`ifndef CLKGEN_I2C_MAP_SVH
`define CLKGEN_I2C_MAP_SVH

`define DEV_ADDR 7'h5C
`define REG_CNT 16
`define BYTE_DONE 4'h8
`define ACK_BIT 4'h8
`define CNT_ZERO 4'h0
`define REG_CLEAR 8'h00
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 160
`define QTR_CYC ((`SCL_PERIOD_NS / `CLK_PERIOD_NS) / 4)
`define QTR_LAST (3'(`QTR_CYC - 1))
`define PH_LOW 2'h0
`define PH_RISE 2'h1
`define PH_SAMPLE 2'h2
`define PH_FALL 2'h3
`define FIFO_DEPTH 2'h2

`endif

/* File: clkgen_i2c_pkg.sv */
// types shared by both ends of the two-wire register link
package clkgen_i2c_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [3:0] ptr_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WR = 4'h5,
    ST_WR_ACK = 4'h6,
    ST_RD = 4'h7,
    ST_RD_ACK = 4'h8
  } slv_state_type;
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BYTE = 2'h2,
    M_STOP = 2'h3
  } mst_state_type;
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } cmd_type;
endpackage

/* File: i2c_link_if.sv */
// open-drain two-wire link joining the master and the register slave
`timescale 1ns/1ps
interface i2c_link_if;
  logic mst_scl_out;
  logic mst_scl_oe;
  logic mst_sda_out;
  logic mst_sda_oe;
  logic slv_sda_out;
  logic slv_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: a line is low while any enabled driver pulls low
  assign scl = ~(mst_scl_oe & ~mst_scl_out);
  assign sda = ~(mst_sda_oe & ~mst_sda_out) & ~(slv_sda_oe & ~slv_sda_out);
  modport device (input scl, input sda, output slv_sda_out, output slv_sda_oe);
  modport host (input scl, input sda, output mst_scl_out, output mst_scl_oe,
                output mst_sda_out, output mst_sda_oe);
endinterface

/* File: clkgen_i2c_slave.sv */
// two-wire slave giving a bus master access to 16 clock generator control bytes
// Overview of operation
// - read/write slave, general call never answered
// - SDA fall while SCL high starts decoding
// - SDA rise while SCL high returns idle
// - master changes SDA only while SCL low
// - master frames commands with START and STOP
// - answer only slave address 1011100 plus R/W
// - never answer EEPROM addresses 1010xxx
// - receiver pulls SDA low on ninth pulse
// - master nack ends read, slave releases SDA
// - write: address, pointer byte, then data bytes
// - partial byte at STOP/START is discarded
// - register updates at its acknowledge
// - write pointer increments, wraps after 16
// - master waits acknowledge before next byte
// - unlimited bytes between START and STOP
// - random read keeps pointer set before restart
// - read sends pointed register MSB first
// - read pointer increments, wraps past 15
// - serial link only in program mode
// - registers cleared at reset and program entry
`timescale 1ns/1ps
`include "clkgen_i2c_map.svh"
module clkgen_i2c_slave (
  input wire logic clk,
  input wire logic sys_rst,
  i2c_link_if.device link,
  input wire logic mode_run,
  output logic [8*`REG_CNT-1:0] ctrl_regs,
  output logic reg_update,
  output clkgen_i2c_pkg::ptr_type reg_update_idx,
  output logic powerdown_req,
  output logic output_enable
);
  import clkgen_i2c_pkg::*;

  function automatic ptr_type next_ptr(input ptr_type p);
    next_ptr = p + 4'h1;
  endfunction

  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic [1:0] mode_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_f_r;
  logic sda_f_r;
  logic scl_p_r;
  logic sda_p_r;
  logic mode_p_r;
  logic scl_f_nxt;
  logic sda_f_nxt;

  // stage 0 is read only by stage 1; the filter looks at stage 1 onward
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      mode_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      mode_p_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      mode_s_r <= {mode_s_r[0], mode_run};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
      mode_p_r <= mode_s_r[1];
    end
  end

  // single-sample glitches are dropped: a level must hold two samples
  always_comb begin
    scl_f_nxt = (scl_s_r[1] == scl_d_r) ? scl_d_r : scl_f_r;
    sda_f_nxt = (sda_s_r[1] == sda_d_r) ? sda_d_r : sda_f_r;
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic enter_prog;
  logic run_mode;

  assign run_mode = mode_s_r[1];
  assign enter_prog = mode_p_r & ~mode_s_r[1];
  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  assign start_seen = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_seen = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  slv_state_type st_r;
  slv_state_type st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  byte_type sh_r;
  byte_type sh_nxt;
  ptr_type ptr_r;
  ptr_type ptr_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic drv_r;
  logic drv_nxt;
  byte_type regs_r [`REG_CNT];
  byte_type regs_nxt [`REG_CNT];
  logic upd_r;
  logic upd_nxt;
  ptr_type upd_idx_r;
  ptr_type upd_idx_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    drv_nxt = drv_r;
    regs_nxt = regs_r;
    upd_nxt = 1'b0;
    upd_idx_nxt = upd_idx_r;
    if (run_mode) begin
      st_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end else if (start_seen) begin
      st_nxt = ST_DEV;
      cnt_nxt = `CNT_ZERO;
      drv_nxt = 1'b0;
    end else if (stop_seen) begin
      st_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end else if (scl_rise) begin
      if (st_r == ST_DEV || st_r == ST_PTR || st_r == ST_WR) begin
        sh_nxt = {sh_r[6:0], sda_f_r};
        cnt_nxt = cnt_r + 4'h1;
      end else if (st_r == ST_RD) begin
        cnt_nxt = cnt_r + 4'h1;
      end else if (st_r == ST_RD_ACK) begin
        nack_nxt = sda_f_r;
      end
    end else if (scl_fall) begin
      case (st_r)
        ST_DEV: begin
          if (cnt_r == `BYTE_DONE) begin
            // general call and 1010xxx fall through as a mismatch
            if (sh_r[7:1] == `DEV_ADDR) begin
              rw_nxt = sh_r[0];
              drv_nxt = 1'b1;
              st_nxt = ST_DEV_ACK;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_DEV_ACK: begin
          cnt_nxt = `CNT_ZERO;
          if (rw_r) begin
            sh_nxt = regs_r[ptr_r];
            drv_nxt = ~regs_r[ptr_r][7];
            st_nxt = ST_RD;
          end else begin
            drv_nxt = 1'b0;
            st_nxt = ST_PTR;
          end
        end
        ST_PTR: begin
          if (cnt_r == `BYTE_DONE) begin
            ptr_nxt = sh_r[3:0];
            drv_nxt = 1'b1;
            st_nxt = ST_PTR_ACK;
          end
        end
        ST_WR: begin
          // only a full byte reaches here, so a cut-short byte never lands
          if (cnt_r == `BYTE_DONE) begin
            regs_nxt[ptr_r] = sh_r;
            upd_nxt = 1'b1;
            upd_idx_nxt = ptr_r;
            ptr_nxt = next_ptr(ptr_r);
            drv_nxt = 1'b1;
            st_nxt = ST_WR_ACK;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          cnt_nxt = `CNT_ZERO;
          drv_nxt = 1'b0;
          st_nxt = ST_WR;
        end
        ST_RD: begin
          if (cnt_r == `BYTE_DONE) begin
            drv_nxt = 1'b0;
            ptr_nxt = next_ptr(ptr_r);
            st_nxt = ST_RD_ACK;
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            drv_nxt = ~sh_r[6];
          end
        end
        ST_RD_ACK: begin
          cnt_nxt = `CNT_ZERO;
          if (nack_r) begin
            drv_nxt = 1'b0;
            st_nxt = ST_IDLE;
          end else begin
            sh_nxt = regs_r[ptr_r];
            drv_nxt = ~regs_r[ptr_r][7];
            st_nxt = ST_RD;
          end
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end
    if (enter_prog) begin
      for (int i = 0; i < `REG_CNT; i++) begin
        regs_nxt[i] = `REG_CLEAR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= `CNT_ZERO;
      sh_r <= `REG_CLEAR;
      ptr_r <= 4'h0;
      rw_r <= 1'b0;
      nack_r <= 1'b1;
      drv_r <= 1'b0;
      upd_r <= 1'b0;
      upd_idx_r <= 4'h0;
      for (int i = 0; i < `REG_CNT; i++) begin
        regs_r[i] <= `REG_CLEAR;
      end
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      drv_r <= drv_nxt;
      upd_r <= upd_nxt;
      upd_idx_r <= upd_idx_nxt;
      regs_r <= regs_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < `REG_CNT; i++) begin
      ctrl_regs[8*i +: 8] = regs_r[i];
    end
  end

  // the pad only ever pulls low; a high bit is a release
  assign link.slv_sda_out = 1'b0;
  assign link.slv_sda_oe = drv_r;
  assign reg_update = upd_r;
  assign reg_update_idx = upd_idx_r;
  // in run mode the shared pins become power-down and output-enable inputs
  assign powerdown_req = run_mode & scl_f_r;
  assign output_enable = run_mode & sda_f_r;
endmodule // clkgen_i2c_slave

/* File: clkgen_i2c_master.sv */
// two-wire bus master that drives the register slave from byte-level commands
`timescale 1ns/1ps
`include "clkgen_i2c_map.svh"
module clkgen_i2c_master (
  input wire logic clk,
  input wire logic sys_rst,
  i2c_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input clkgen_i2c_pkg::cmd_type cmd_kind,
  input clkgen_i2c_pkg::byte_type cmd_data,
  input wire logic cmd_ack,
  output logic rd_valid,
  input wire logic rd_ready,
  output clkgen_i2c_pkg::byte_type rd_data,
  output logic wr_nack,
  output logic busy
);
  import clkgen_i2c_pkg::*;

  logic [1:0] sda_s_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_s_r <= 2'h3;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  mst_state_type st_r;
  mst_state_type st_nxt;
  logic [2:0] q_r;
  logic [2:0] q_nxt;
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  byte_type sh_r;
  byte_type sh_nxt;
  logic rd_r;
  logic rd_nxt;
  logic ack_r;
  logic ack_nxt;
  logic scl_r;
  logic scl_nxt;
  logic sda_r;
  logic sda_nxt;
  logic nack_r;
  logic nack_nxt;
  byte_type mem_r [2];
  byte_type mem_nxt [2];
  logic wp_r;
  logic wp_nxt;
  logic rp_r;
  logic rp_nxt;
  logic [1:0] fcnt_r;
  logic [1:0] fcnt_nxt;
  logic tick;
  logic push;
  logic pop;
  logic take;

  assign tick = (q_r == `QTR_LAST);
  assign pop = rd_valid & rd_ready;
  // a read is taken only with a free buffer slot, so a stalled reader
  // holds SCL low between bytes instead of losing one
  assign cmd_ready = (st_r == M_IDLE) && (cmd_kind != CMD_READ || fcnt_r != `FIFO_DEPTH);
  assign take = cmd_valid & cmd_ready;

  always_comb begin
    st_nxt = st_r;
    q_nxt = (st_r == M_IDLE || tick) ? 3'h0 : q_r + 3'h1;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    ack_nxt = ack_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    nack_nxt = nack_r;
    push = 1'b0;
    if (st_r == M_IDLE) begin
      if (take) begin
        ph_nxt = `PH_LOW;
        bit_nxt = `CNT_ZERO;
        sh_nxt = cmd_data;
        rd_nxt = (cmd_kind == CMD_READ);
        ack_nxt = cmd_ack;
        case (cmd_kind)
          CMD_START: begin
            sda_nxt = 1'b1;
            st_nxt = M_START;
          end
          CMD_STOP: begin
            // outside a frame scl is high; pulling sda would fake a start
            if (!scl_r) begin
              sda_nxt = 1'b0;
              st_nxt = M_STOP;
            end
          end
          default: begin
            if (!scl_r) begin
              sda_nxt = (cmd_kind == CMD_READ) ? 1'b1 : cmd_data[7];
              st_nxt = M_BYTE;
            end
          end
        endcase
      end
    end else if (tick) begin
      ph_nxt = ph_r + 2'h1;
      case (ph_r)
        `PH_LOW: begin
          scl_nxt = 1'b1;
        end
        `PH_RISE: begin
          if (st_r == M_START) begin
            sda_nxt = 1'b0;
          end else if (st_r == M_STOP) begin
            sda_nxt = 1'b1;
          end
        end
        `PH_SAMPLE: begin
          if (st_r == M_BYTE) begin
            scl_nxt = 1'b0;
            if (bit_r == `ACK_BIT) begin
              if (!rd_r) begin
                nack_nxt = sda_s_r[1];
              end
            end else if (rd_r) begin
              sh_nxt = {sh_r[6:0], sda_s_r[1]};
            end
          end else if (st_r == M_START) begin
            scl_nxt = 1'b0;
          end
        end
        default: begin
          if (st_r != M_BYTE || bit_r == `ACK_BIT) begin
            push = (st_r == M_BYTE) && rd_r;
            st_nxt = M_IDLE;
          end else begin
            bit_nxt = bit_r + 4'h1;
            if (bit_r + 4'h1 == `ACK_BIT) begin
              sda_nxt = rd_r ? ~ack_r : 1'b1;
            end else if (rd_r) begin
              sda_nxt = 1'b1;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              sda_nxt = sh_r[6];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    fcnt_nxt = fcnt_r;
    if (push) begin
      mem_nxt[wp_r] = sh_r;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      fcnt_nxt = fcnt_r + 2'h1;
    end else if (pop && !push) begin
      fcnt_nxt = fcnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= M_IDLE;
      q_r <= 3'h0;
      ph_r <= `PH_LOW;
      bit_r <= `CNT_ZERO;
      sh_r <= `REG_CLEAR;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      nack_r <= 1'b0;
      mem_r <= '{default: `REG_CLEAR};
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      fcnt_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      nack_r <= nack_nxt;
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  assign link.mst_scl_out = 1'b0;
  assign link.mst_scl_oe = ~scl_r;
  assign link.mst_sda_out = 1'b0;
  assign link.mst_sda_oe = ~sda_r;
  assign rd_valid = (fcnt_r != 2'h0);
  assign rd_data = mem_r[rp_r];
  assign wr_nack = nack_r;
  assign busy = (st_r != M_IDLE);
endmodule // clkgen_i2c_master

/* File: clkgen_i2c_chk.sv */
// assertions on the open-drain link between the master and the register slave
`timescale 1ns/1ps
module clkgen_i2c_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mst_scl_out,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_out,
  input wire logic mst_sda_oe,
  input wire logic slv_sda_out,
  input wire logic slv_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence start_seen;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_seen;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence ack_onset;
    $rose(slv_sda_oe);
  endsequence
  AST_OPEN_DRAIN: assert property (!slv_sda_out && !mst_sda_out && !mst_scl_out)
    else $error("a link driver pushes a high level");
  AST_ACK_SCL_LOW: assert property (ack_onset |-> !scl)
    else $error("slave began pulling sda while scl high");
  AST_SLV_HOLD: assert property (scl && $past(scl) |-> $stable(slv_sda_oe))
    else $error("slave changed sda during scl high");
  AST_ACK_LENGTH: assert property (ack_onset |-> slv_sda_oe [*8])
    else $error("slave released sda too early");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  AST_STOP_IDLE: assert property (stop_seen |-> !slv_sda_oe [*8])
    else $error("slave drove sda after stop");
  AST_START_QUIET: assert property (start_seen |-> !slv_sda_oe [*8])
    else $error("slave drove sda right after start");
endmodule // clkgen_i2c_chk

/* File: tb.sv */
// self-checking bench: master and register slave joined over the two-wire link
`timescale 1ns/1ps
module tb;
  import clkgen_i2c_pkg::*;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_run = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd_kind = CMD_START;
  byte_type cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic rd_ready = 1'b0;
  logic cmd_ready, rd_valid, wr_nack, busy, reg_update, powerdown_req, output_enable;
  byte_type rd_data;
  ptr_type reg_update_idx;
  ptr_type upd_idx = 4'h0;
  logic [127:0] ctrl_regs;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int mem [16] = '{default: 0};
  logic [31:0] seed = 32'hE636B885;
  byte_type bad [5] = '{8'h00, 8'hA0, 8'hAF, 8'hBA, 8'h38};
  i2c_link_if link ();
  clkgen_i2c_master clkgen_i2c_master_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
    .cmd_ack(cmd_ack), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .wr_nack(wr_nack), .busy(busy));
  clkgen_i2c_slave clkgen_i2c_slave_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .mode_run(mode_run), .ctrl_regs(ctrl_regs), .reg_update(reg_update),
    .reg_update_idx(reg_update_idx), .powerdown_req(powerdown_req),
    .output_enable(output_enable));
  clkgen_i2c_chk clkgen_i2c_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .mst_scl_out(link.mst_scl_out), .mst_scl_oe(link.mst_scl_oe),
    .mst_sda_out(link.mst_sda_out), .mst_sda_oe(link.mst_sda_oe),
    .slv_sda_out(link.slv_sda_out), .slv_sda_oe(link.slv_sda_oe),
    .scl(link.scl), .sda(link.sda));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (reg_update === 1'b1) begin
      upd_idx <= reg_update_idx;
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end
  function automatic byte_type rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [127:0] regs_exp();
    logic [127:0] v;
    for (int i = 0; i < 16; i++) v[8*i +: 8] = mem[i][7:0];
    return v;
  endfunction
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // entered just after an edge; waits until the command has run out on the wire
  task automatic cmd(input cmd_type k, input byte_type d, input logic a);
    cmd_kind = k;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    // ready is judged settled, well before the edge that takes the command
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (busy === 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic pop(input int q);
    // let an edge pass so a previous pop's ready is never lowered and raised at once
    @(posedge clk);
    #1;
    for (int k = 0; k < 8 && rd_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(rd_valid, 128'h1);
    chk(rd_data, 128'(mem[q][7:0]));
    rd_ready = 1'b1;
    @(posedge clk);
    #1 rd_ready = 1'b0;
  endtask
  task automatic wr_ptr(input byte_type p);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, 8'hB8, 1'b0);
    chk(wr_nack, 128'h0);
    cmd(CMD_WRITE, p, 1'b0);
  endtask
  task automatic wr_seq(input byte_type p, input int n);
    byte_type d;
    int q;
    wr_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      q = (int'(p[3:0]) + i) % 16;
      cmd(CMD_WRITE, d, 1'b0);
      mem[q] = d;
      chk(wr_nack, 128'h0);
      chk(upd_idx, 128'(q));
      chk(ctrl_regs, regs_exp());
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask
  task automatic rd_seq(input byte_type p, input int n);
    wr_ptr(p);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, 8'hB9, 1'b0);
    chk(wr_nack, 128'h0);
    for (int i = 0; i < n; i++) begin
      cmd(CMD_READ, 8'h00, i < n - 1);
      pop((int'(p[3:0]) + i) % 16);
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(ctrl_regs, 128'h0);
    chk(powerdown_req, 128'h0);
    foreach (bad[i]) begin
      cmd(CMD_START, 8'h00, 1'b0);
      cmd(CMD_WRITE, bad[i], 1'b0);
      chk(wr_nack, 128'h1);
      cmd(CMD_STOP, 8'h00, 1'b0);
    end
    wr_seq(8'hF3, 1);
    wr_seq(8'h0E, 4);
    wr_seq(8'h00, 17);
    rd_seq(8'h03, 1);
    rd_seq(8'h0D, 5);
    // two words wait in the buffer while the reader stalls; a third read is held off
    wr_ptr(8'h05);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, 8'hB9, 1'b0);
    cmd(CMD_READ, 8'h00, 1'b1);
    cmd(CMD_READ, 8'h00, 1'b1);
    #1;
    chk(cmd_ready, 128'h0);
    pop(5);
    pop(6);
    cmd(CMD_READ, 8'h00, 1'b0);
    pop(7);
    cmd(CMD_STOP, 8'h00, 1'b0);
    // run mode: pins become plain level inputs and the slave stays deaf
    mode_run = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({powerdown_req, output_enable}, 128'h3);
    cmd(CMD_START, 8'h00, 1'b0);
    chk(powerdown_req, 128'h0);
    cmd(CMD_WRITE, 8'hB8, 1'b0);
    chk(wr_nack, 128'h1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    mode_run = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    mem = '{default: 0};
    chk(ctrl_regs, 128'h0);
    wr_seq(8'h0F, 2);
    rd_seq(8'h0F, 3);
    report_and_stop();
  end
endmodule // tb
